// [core/adc_ctl.sv]
`timescale 1ns/1ps
`include "adc_ctl_regs.svh"
// Functional notes
// - IEN bits 0..2 enable ready, sample, conversion
// - IEN bits 3,4,7 enable sequence, overrun, watchdog
// - IEN writes only while start reads zero
// - Enable set only when control all zero
// - Disable powers off; needs enabled, not running
// - Start begins conversion; needs enabled, no disable
// - Stop halts conversion; needs start, no disable
// - Calibrate until done; only while disabled
// - DMA enable; circular mode only with DMA
// - Scan direction upward or downward
// - Resolution code 12/10/8/6 bits
// - Right or left result alignment
// - Select one of eight trigger events
// - Trigger edge: off, rise, fall, both
// - Overrun keeps or overwrites the result
// - Interrupt only for enabled, set flags
// - One DMA request per conversion; none while overrun is flagged
module adc_ctl (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire adc_ctl_pkg::conv_evt_s evt,
  input  wire logic                  cal_done,
  input  wire logic [11:0]           conv_data,
  input  wire logic [7:0]            ext_trig,
  input  wire logic                  dma_ack,
  output logic                       conv_power,
  output logic                       cal_run,
  output logic                       conv_go,
  output logic                       scan_dir,
  output adc_ctl_pkg::res_sel_t      resolution_sel,
  output logic [15:0]                result,
  output logic                       dma_req,
  output logic                       dma_circular_sel,
  output logic                       irq
);
  import adc_ctl_pkg::*;

  logic [7:0]  status_reg;     // Sticky event flags.
  logic [7:0]  status_set;     // Event strobes this cycle.
  logic [7:0]  irq_en_reg;     // Interrupt enables.
  logic [31:0] cfg_reg;        // Configuration word.
  logic        conv_on_reg;    // Converter enabled.
  logic        off_reg;        // Disable command pending.
  logic        start_reg;      // Start command active.
  logic        stop_reg;       // Stop command pending.
  logic        cal_reg;        // Calibration running.
  logic [31:0] prdata_reg;     // Read data captured in setup.
  logic [15:0] result_reg;     // Aligned conversion result.
  logic        dma_req_reg;    // DMA request level.
  logic        go_reg;         // Conversion request pulse.
  logic        trig_prev_reg;  // Last sample of the trigger.
  seq_state_e  seq_reg;        // Sequencer state.
  logic        wr;             // Write access phase.
  logic        wr_ctl;         // Write to control.
  logic        ctl_zero;       // All control bits clear.
  logic        set_on;         // Accepted enable command.
  logic        set_off;        // Accepted disable command.
  logic        set_start;      // Accepted start command.
  logic        set_stop;       // Accepted stop command.
  logic        set_cal;        // Accepted calibrate command.
  logic        mapped;         // Address hits a register.
  logic        trig_now;       // Selected trigger level.
  logic        trig_fire;      // Trigger condition met.
  logic        ovr_evt;        // Overrun detected.
  logic        pending;        // Previous result unread.
  logic [31:0] ctl_word;       // Control register image.
  logic [15:0] shaped;         // Result after resolution.

  // The slave always answers in the first access cycle.
  assign pready = 1'b1;
  assign wr     = psel & penable & pwrite;
  assign wr_ctl = wr && (paddr == `OFS_CONTROL);

  // Unmapped addresses end with an error answer.
  always_comb begin
    case (paddr)
      `OFS_STATUS, `OFS_IRQ_EN, `OFS_CONTROL, `OFS_CONFIG1, `OFS_IRQ_CLR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  // Control image; the gaps stay zero.
  // reserved reads zero
  always_comb begin
    ctl_word = `RESET_VALUE;
    ctl_word[`CTL_ON]    = conv_on_reg;
    ctl_word[`CTL_OFF]   = off_reg;
    ctl_word[`CTL_START] = start_reg;
    ctl_word[`CTL_STOP]  = stop_reg;
    ctl_word[`CTL_CAL]   = cal_reg;
  end
  assign ctl_zero = ~|ctl_word;

  // Command guards; a zero bit or failed guard does nothing.
  // guarded command writes
  assign set_on    = wr_ctl & pwdata[`CTL_ON] & ctl_zero;
  assign set_off   = wr_ctl & pwdata[`CTL_OFF] & conv_on_reg & ~start_reg;
  assign set_start = wr_ctl & pwdata[`CTL_START] & conv_on_reg & ~off_reg;
  assign set_stop  = wr_ctl & pwdata[`CTL_STOP] & start_reg & ~off_reg;
  assign set_cal   = wr_ctl & pwdata[`CTL_CAL] & ~conv_on_reg & ~pwdata[`CTL_ON];

  // Read data is captured in the setup cycle so it comes from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= `RESET_VALUE;
    end else if (psel && !penable) begin
      case (paddr)
        `OFS_STATUS:  prdata_reg <= {24'h000000, status_reg};
        `OFS_IRQ_EN:  prdata_reg <= {24'h000000, irq_en_reg};
        `OFS_CONTROL: prdata_reg <= ctl_word;
        `OFS_CONFIG1: prdata_reg <= cfg_reg;
        default:      prdata_reg <= `RESET_VALUE;
      endcase
    end
  end
  assign prdata = prdata_reg;

  // Interrupt enables change only while no conversion runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= 8'h00;
    end else if (wr && paddr == `OFS_IRQ_EN && !start_reg) begin
      irq_en_reg <= 8'(pwdata & `IEN_MASK);
    end
  end

  // Configuration follows the same no-conversion guard.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `RESET_VALUE;
    end else if (wr && paddr == `OFS_CONFIG1 && !start_reg) begin
      cfg_reg <= pwdata & `CFG1_MASK;
    end
  end

  // Enable bit: set by software, cleared when disable completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_on_reg <= 1'b0;
    end else if (set_on) begin
      conv_on_reg <= 1'b1;
    end else if (off_reg) begin
      conv_on_reg <= 1'b0;
    end
  end

  // Disable command lasts one cycle, then hardware clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_reg <= 1'b0;
    end else begin
      off_reg <= set_off;
    end
  end

  // Start stays set until stopped or the sequence ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
    end else if (set_start) begin
      start_reg <= 1'b1;
    end else if (stop_reg || evt.seq_end) begin
      start_reg <= 1'b0;
    end
  end

  // Stop command lasts one cycle and takes start down with it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= set_stop;
    end
  end

  // Calibration runs until the macro reports completion.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_reg <= 1'b0;
    end else if (set_cal) begin
      cal_reg <= 1'b1;
    end else if (cal_done) begin
      cal_reg <= 1'b0;
    end
  end

  // Selected trigger line and its edge detection.
  // trigger source select
  assign trig_now = ext_trig[cfg_reg[`CFG_TRG_LO +: 3]];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_now;
    end
  end

  // Edge polarity decides when a request may start.
  always_comb begin
    case (cfg_reg[`CFG_EDGE_LO +: 2])
      2'h0:    trig_fire = 1'b1;
      2'h1:    trig_fire = trig_now & ~trig_prev_reg;
      2'h2:    trig_fire = ~trig_now & trig_prev_reg;
      default: trig_fire = trig_now ^ trig_prev_reg;
    endcase
  end

  // Sequencer: issue one request, wait for its end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= SEQ_IDLE;
      go_reg  <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      case (seq_reg)
        SEQ_IDLE: begin
          // A request needs an active start and no stop pending.
          if (start_reg && !stop_reg && trig_fire) begin
            go_reg  <= 1'b1;
            seq_reg <= SEQ_BUSY;
          end
        end
        SEQ_BUSY: begin
          // Leave on the end of conversion or on a stop.
          if (evt.conv_end || !start_reg) begin
            seq_reg <= SEQ_IDLE;
          end
        end
        default: seq_reg <= SEQ_IDLE;
      endcase
    end
  end

  // Overrun: a new result while the previous one is unread.
  assign pending = cfg_reg[`CFG_DMA_ON] ? dma_req_reg : status_reg[`ST_CONV_END];
  assign ovr_evt = evt.conv_end & pending;

  // Resolution trim and alignment of the raw value.
  always_comb begin
    shaped = {4'h0, conv_data >> {cfg_reg[`CFG_RES_LO +: 2], 1'b0}};
    if (cfg_reg[`CFG_ALIGN]) begin
      shaped = {conv_data, 4'h0};
    end
  end

  // Result register; overrun handling decides if it updates.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= 16'h0000;
    end else if (evt.conv_end && (!ovr_evt || cfg_reg[`CFG_OVR])) begin
      result_reg <= shaped;
    end
  end

  // DMA request per conversion; held off while overrun is flagged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req_reg <= 1'b0;
    end else if (evt.conv_end && cfg_reg[`CFG_DMA_ON] && !ovr_evt &&
                 !status_reg[`ST_OVERRUN]) begin
      dma_req_reg <= 1'b1;
    end else if (dma_ack || !cfg_reg[`CFG_DMA_ON]) begin
      dma_req_reg <= 1'b0;
    end
  end

  // Event strobes map onto status bit positions.
  always_comb begin
    status_set    = 8'h00;
    status_set[0] = evt.ready;
    status_set[1] = evt.sample_end;
    status_set[2] = evt.conv_end;
    status_set[3] = evt.seq_end;
    status_set[4] = ovr_evt;
    status_set[7] = evt.watchdog;
  end

  // Sticky flags, one per bit; a set beats a same-cycle clear.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          status_reg[gi] <= 1'b0;
        end else if (status_set[gi]) begin
          status_reg[gi] <= 1'b1;
        end else if (wr && paddr == `OFS_IRQ_CLR && pwdata[gi]) begin
          status_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(status_reg & irq_en_reg);

  // Outputs toward the analog macro and DMA.
  assign conv_power       = conv_on_reg;
  assign cal_run          = cal_reg;
  assign conv_go          = go_reg;
  assign scan_dir         = cfg_reg[`CFG_SCAN];
  assign resolution_sel   = cfg_reg[`CFG_RES_LO +: 2];
  assign result           = result_reg;
  assign dma_req          = dma_req_reg;
  assign dma_circular_sel = cfg_reg[`CFG_DMA_ON] & cfg_reg[`CFG_DMA_CIRC];

  // Enable writes during a conversion leave the enables untouched.
  property p_ien_hold;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `OFS_IRQ_EN && start_reg) |=> $stable(irq_en_reg);
  endproperty
  a_ien_hold: assert property (p_ien_hold) else $error("enable changed during run");
  // Enable only rises from an all-zero control register.
  property p_on_guard;
    @(posedge pclk) disable iff (!presetn) $rose(conv_on_reg) |-> $past(ctl_zero);
  endproperty
  a_on_guard: assert property (p_on_guard) else $error("enable set with control busy");
  // A disable clears itself and the enable within two cycles.
  property p_off_done;
    @(posedge pclk) disable iff (!presetn) set_off |=> off_reg ##1 (!off_reg && !conv_on_reg);
  endproperty
  a_off_done: assert property (p_off_done) else $error("disable did not power off");
  // Start only rises while enabled without a pending disable.
  property p_start_guard;
    @(posedge pclk) disable iff (!presetn) $rose(start_reg) |-> $past(conv_on_reg && !off_reg);
  endproperty
  a_start_guard: assert property (p_start_guard) else $error("start set illegally");
  // An accepted stop clears start two cycles later.
  property p_stop_clear;
    @(posedge pclk) disable iff (!presetn) set_stop |=> stop_reg ##1 (!stop_reg && !start_reg);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop did not halt");
  // Calibration never starts while enabled; the hold is checked only in the cycle it rises.
  property p_cal_hold;
    @(posedge pclk) disable iff (!presetn)
      $rose(cal_reg) |-> $past(!conv_on_reg) ##0 (cal_reg throughout (!cal_done)[*1]);
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("calibration misbehaved");
  // Interrupt line matches enabled flags.
  property p_irq;
    @(posedge pclk) disable iff (!presetn) irq == |(status_reg & irq_en_reg & 8'(`IEN_MASK));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch");
  // Each clean conversion with DMA raises one request.
  property p_dma;
    @(posedge pclk) disable iff (!presetn)
      (evt.conv_end && cfg_reg[0] && !pending && !status_reg[4]) |=> dma_req;
  endproperty
  a_dma: assert property (p_dma) else $error("missing DMA request");
  // Overrun with keep mode leaves the result unchanged.
  property p_ovr_keep;
    @(posedge pclk) disable iff (!presetn)
      (ovr_evt && !cfg_reg[`CFG_OVR]) |=> $stable(result_reg);
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("result overwritten");
  // Reserved configuration bits never become set.
  property p_cfg_rsvd;
    @(posedge pclk) disable iff (!presetn) (cfg_reg & ~`CFG1_MASK) == 32'h00000000;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved bit set");

endmodule : adc_ctl

// [core/adc_ctl_regs.svh]
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH
// Register byte offsets.
`define OFS_STATUS   12'h000
`define OFS_IRQ_EN   12'h004
`define OFS_CONTROL  12'h008
`define OFS_CONFIG1  12'h00c
`define OFS_IRQ_CLR  12'h018
// Control bit positions.
`define CTL_ON       0
`define CTL_OFF      1
`define CTL_START    2
`define CTL_STOP     4
`define CTL_CAL      31
// Configuration bit positions.
`define CFG_DMA_ON   0
`define CFG_DMA_CIRC 1
`define CFG_SCAN     2
`define CFG_RES_LO   3
`define CFG_ALIGN    5
`define CFG_TRG_LO   6
`define CFG_EDGE_LO  10
`define CFG_OVR      12
// Status and enable bit positions.
`define ST_OVERRUN   4
`define ST_CONV_END  2
// Writable masks, reset values.
`define IEN_MASK     32'h0000009f
`define CFG1_MASK    32'h00001dff
`define RESET_VALUE  32'h00000000
`endif

// [core/adc_ctl_pkg.sv]
package adc_ctl_pkg;
  // Event strobes coming back from the analog converter macro.
  typedef struct packed {
    logic watchdog;  // Analog watchdog hit.
    logic overrun;   // Unused here; overrun is detected locally.
    logic seq_end;   // Last channel of the sequence converted.
    logic conv_end;  // One conversion finished.
    logic sample_end;// Sampling phase finished.
    logic ready;     // Converter became ready.
  } conv_evt_s;
  // Conversion sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_BUSY
  } seq_state_e;
  // Resolution selection codes.
  typedef logic [1:0] res_sel_t;
endpackage : adc_ctl_pkg

// [verif/tb.sv]
`timescale 1ns/1ps
`include "adc_ctl_regs.svh"
// Self-checking bench for the converter control register block.
module tb;
  import adc_ctl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, conv_data;
  logic [31:0] pwdata, prdata, rd;
  conv_evt_s   evt;
  logic        cal_done, dma_ack, conv_power, cal_run, conv_go, scan_dir;
  logic        dma_req, dma_circular_sel, irq, seen;
  logic [7:0]  ext_trig;
  res_sel_t    resolution_sel;
  logic [15:0] result;
  int          error_cnt, checks_done, cycles;

  // Device under test, every pin driven or watched by the bench.
  adc_ctl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .cal_done(cal_done), .conv_data(conv_data),
    .ext_trig(ext_trig), .dma_ack(dma_ack), .conv_power(conv_power), .cal_run(cal_run),
    .conv_go(conv_go), .scan_dir(scan_dir), .resolution_sel(resolution_sel),
    .result(result), .dma_req(dma_req), .dma_circular_sel(dma_circular_sel), .irq(irq));

  // Free-running 50 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("Summary: %0d checks, %0d mismatches", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // Cuts a hung run short.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Compares one sampled value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One bus transfer: setup, then access until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the global cycle ceiling ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write; one more edge lets the written state settle before any check.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge pclk);
  endtask : wr

  // Register read compared with an expectation.
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
    chk(err, 1'b0, "mapped access error");
  endtask : rdchk

  // Watches a number of edges for a conversion request.
  task automatic wait_go(input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge pclk);
      if (conv_go === 1'b1) seen = 1'b1;
    end
  endtask : wait_go

  // One-cycle converter event; returns once registered effects have landed.
  task automatic ev(input logic [5:0] e, input logic [11:0] d);
    @(posedge pclk);
    evt <= e;
    conv_data <= d;
    @(posedge pclk);
    evt <= 6'h00;
    repeat (2) @(posedge pclk);
  endtask : ev

  // Reset values and an unmapped access.
  task automatic t_reset;
    rdchk(`OFS_IRQ_EN, 32'h0, "ien reset");
    rdchk(`OFS_CONTROL, 32'h0, "ctrl reset");
    rdchk(`OFS_CONFIG1, 32'h0, "cfg reset");
    chk({conv_power, cal_run, dma_req, irq}, 4'h0, "outputs reset");
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    $display("t_reset done");
  endtask : t_reset

  // Writable fields, reserved bits and decoded outputs.
  task automatic t_fields;
    wr(`OFS_IRQ_EN, 32'hffffffff);
    rdchk(`OFS_IRQ_EN, 32'h0000009f, "ien mask");
    wr(`OFS_IRQ_EN, 32'h0);
    wr(`OFS_CONFIG1, 32'hffffffff);
    rdchk(`OFS_CONFIG1, 32'h00001dff, "cfg mask");
    chk({scan_dir, dma_circular_sel}, 2'b11, "scan and circular");
    wr(`OFS_CONFIG1, 32'h2);
    chk(dma_circular_sel, 1'b0, "circular without dma");
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_CONFIG1, i << `CFG_RES_LO);
      chk(resolution_sel, i[1:0], "resolution code");
    end
    wr(`OFS_CONFIG1, 32'h0);
    $display("t_fields done");
  endtask : t_fields

  // Command bits and their guards.
  task automatic t_cmds;
    wr(`OFS_CONTROL, 32'h0);
    rdchk(`OFS_CONTROL, 32'h0, "zero write");
    wr(`OFS_CONTROL, 32'h1 << `CTL_START);
    rdchk(`OFS_CONTROL, 32'h0, "start while off");
    wr(`OFS_CONTROL, 32'h1 << `CTL_STOP);
    rdchk(`OFS_CONTROL, 32'h0, "stop while idle");
    wr(`OFS_CONTROL, 32'h1 << `CTL_OFF);
    rdchk(`OFS_CONTROL, 32'h0, "disable while off");
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL);
    chk(cal_run, 1'b1, "cal running");
    wr(`OFS_CONTROL, 32'h1 << `CTL_ON);
    rdchk(`OFS_CONTROL, 32'h80000000, "enable during cal");
    @(posedge pclk);
    cal_done <= 1'b1;
    @(posedge pclk);
    cal_done <= 1'b0;
    rdchk(`OFS_CONTROL, 32'h0, "cal cleared");
    wr(`OFS_CONTROL, 32'h1 << `CTL_ON);
    rdchk(`OFS_CONTROL, 32'h1, "enable");
    chk(conv_power, 1'b1, "power on");
    wr(`OFS_CONTROL, 32'h1 << `CTL_CAL);
    rdchk(`OFS_CONTROL, 32'h1, "cal while on");
    wr(`OFS_CONTROL, 32'h1 << `CTL_OFF);
    rdchk(`OFS_CONTROL, 32'h0, "disable");
    chk(conv_power, 1'b0, "power off");
    $display("t_cmds done");
  endtask : t_cmds

  // Conversion with interrupts, overrun that keeps old data, stop.
  task automatic t_conv;
    wr(`OFS_IRQ_EN, 32'h14);
    wr(`OFS_CONFIG1, 32'h1 << `CFG_RES_LO);
    wr(`OFS_CONTROL, 32'h1);
    wr(`OFS_CONTROL, 32'h1 << `CTL_START);
    wait_go(6);
    chk(seen, 1'b1, "software start");
    rdchk(`OFS_CONTROL, 32'h5, "started");
    wr(`OFS_IRQ_EN, 32'h9f);
    rdchk(`OFS_IRQ_EN, 32'h14, "ien locked");
    wr(`OFS_CONTROL, 32'h1 << `CTL_OFF);
    rdchk(`OFS_CONTROL, 32'h5, "disable while running");
    ev(6'h04, 12'habc);
    chk(result, 16'h02af, "ten bit right");
    chk(irq, 1'b1, "conv irq");
    ev(6'h04, 12'h123);
    chk(result, 16'h02af, "overrun keeps");
    rdchk(`OFS_STATUS, 32'h14, "overrun flag");
    wr(`OFS_IRQ_CLR, 32'h14);
    rdchk(`OFS_STATUS, 32'h0, "flags cleared");
    chk(irq, 1'b0, "irq cleared");
    ev(6'h01, 12'h0);
    chk(irq, 1'b0, "masked ready");
    wr(`OFS_IRQ_CLR, 32'h1);
    wr(`OFS_CONTROL, 32'h1 << `CTL_STOP);
    rdchk(`OFS_CONTROL, 32'h1, "stopped");
    wr(`OFS_CONTROL, 32'h1 << `CTL_OFF);
    $display("t_conv done");
  endtask : t_conv

  // DMA requests, left alignment and overwrite on overrun.
  task automatic t_dma;
    wr(`OFS_CONFIG1, 32'h1021);
    chk(dma_circular_sel, 1'b0, "single mode");
    wr(`OFS_CONTROL, 32'h1);
    wr(`OFS_CONTROL, 32'h1 << `CTL_START);
    ev(6'h04, 12'h5a5);
    chk(result, 16'h5a50, "left align");
    chk(dma_req, 1'b1, "dma request");
    ev(6'h04, 12'h123);
    chk(result, 16'h1230, "overrun overwrites");
    @(posedge pclk);
    dma_ack <= 1'b1;
    @(posedge pclk);
    dma_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(dma_req, 1'b0, "dma acknowledged");
    wr(`OFS_CONTROL, 32'h1 << `CTL_STOP);
    wr(`OFS_CONTROL, 32'h1 << `CTL_OFF);
    wr(`OFS_IRQ_CLR, 32'hff);
    $display("t_dma done");
  endtask : t_dma

  // Rising- and falling-edge hardware trigger on one selected line.
  task automatic t_trig;
    wr(`OFS_CONFIG1, (32'h5 << `CFG_TRG_LO) | (32'h1 << `CFG_EDGE_LO));
    wr(`OFS_CONTROL, 32'h1);
    wr(`OFS_CONTROL, 32'h1 << `CTL_START);
    wait_go(4);
    chk(seen, 1'b0, "no trigger yet");
    ext_trig <= 8'h10;
    wait_go(4);
    chk(seen, 1'b0, "other line");
    ext_trig <= 8'h30;
    wait_go(4);
    chk(seen, 1'b1, "rising edge");
    ev(6'h04, 12'h001);
    ext_trig <= 8'h00;
    wait_go(4);
    chk(seen, 1'b0, "falling ignored");
    wr(`OFS_CONTROL, 32'h1 << `CTL_STOP);
    ext_trig <= 8'h20;
    wr(`OFS_CONFIG1, (32'h5 << `CFG_TRG_LO) | (32'h2 << `CFG_EDGE_LO));
    wr(`OFS_CONTROL, 32'h1 << `CTL_START);
    wait_go(4);
    chk(seen, 1'b0, "high level ignored");
    ext_trig <= 8'h00;
    wait_go(4);
    chk(seen, 1'b1, "falling edge");
    wr(`OFS_CONTROL, 32'h1 << `CTL_STOP);
    wr(`OFS_CONTROL, 32'h1 << `CTL_OFF);
    $display("t_trig done");
  endtask : t_trig

  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    evt = 6'h00;
    cal_done = 1'b0;
    conv_data = 12'h0;
    ext_trig = 8'h00;
    dma_ack = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fields();
    t_cmds();
    t_conv();
    t_dma();
    t_trig();
    give_verdict();
  end
endmodule : tb
